// >>> core/jgm_pin_mux.sv
// Test-port / general-purpose pin multiplexer with access-port controller
`timescale 1ns/1ps

// Function
// RULE_01 - After reset all four pins take their test-port function automatically.
// RULE_02 - Alternate function needs both peripheral enable and peripheral select set.
// RULE_03 - Test data input is captured on every rising test-clock edge; the code captures it only in shift-instruction and shift-data states.
// RULE_04 - Test data output drives only in shift-instruction or shift-data states.
// RULE_05 - Test data output changes only on falling test-clock edges.
// RULE_06 - In port function each pin's direction is set by software independently.
// RULE_07 - The external, possibly gated, test clock clocks all test logic.
// RULE_08 - After reset the data-output pin is in its test-port output function.
// RULE_09 - Mode select is sampled on rising test-clock edges to step the controller.
// RULE_10 - A pin in port function feeds its test input a pulled-up high.
module jgm_pin_mux #(
  parameter int unsigned NUM_PINS = jgm_pkg::NUM_PINS
) (
  // System clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Test clock (link domain)
  input  wire logic                 i_tck,
  // Pin selection, system domain
  input  wire logic [NUM_PINS-1:0]  i_per_en,
  input  wire logic [NUM_PINS-1:0]  i_per_sel,
  // Port function control, system domain
  input  wire logic [NUM_PINS-1:0]  i_gpio_dir,
  input  wire logic [NUM_PINS-1:0]  i_gpio_out,
  output logic      [NUM_PINS-1:0]  o_gpio_in,
  output logic      [NUM_PINS-1:0]  o_alt_active,
  // Pads
  input  wire logic [NUM_PINS-1:0]  i_pad,
  output jgm_pkg::jgm_pad_drv_t     o_pad_drv
);

  if (NUM_PINS != jgm_pkg::NUM_PINS) begin : g_chk
    $error("jgm_pin_mux: NUM_PINS must be 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // System-domain selection and port configuration
  logic [NUM_PINS-1:0] alt_sel;
  logic [NUM_PINS-1:0] gpio_dir;
  logic [NUM_PINS-1:0] gpio_out;
  // RULE_02 both selects
  wire  [NUM_PINS-1:0] next_alt_sel = i_per_en & i_per_sel;

  // RULE_01 primary after reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      alt_sel  <= jgm_pkg::RST_ALT_SEL;
      gpio_dir <= jgm_pkg::RST_CFG;
      gpio_out <= jgm_pkg::RST_CFG;
    end else begin
      alt_sel  <= next_alt_sel;
      gpio_dir <= i_gpio_dir;
      gpio_out <= i_gpio_out;
    end
  end

  assign o_alt_active = alt_sel;

  jgm_sync #(.WIDTH(NUM_PINS), .RST_VAL(jgm_pkg::RST_CFG)) u_gpio_in_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_pad),
    .o_q   (o_gpio_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Selection crossed into the test-clock domain
  logic [NUM_PINS-1:0] alt_t;

  jgm_sync #(.WIDTH(NUM_PINS), .RST_VAL(jgm_pkg::RST_ALT_SEL)) u_alt_sync (
    .i_clk (i_tck),
    .i_rst (i_rst),
    .i_d   (alt_sel),
    .o_q   (alt_t)
  );

  // RULE_10 pulled-up inputs
  wire tms_eff = alt_t[jgm_pkg::PIN_TMS] | i_pad[jgm_pkg::PIN_TMS];
  wire tdi_eff = alt_t[jgm_pkg::PIN_TDI] | i_pad[jgm_pkg::PIN_TDI];

  ////////////////////////////////////////////////////////////////////////////
  // Access-port controller, rising test-clock edges
  jgm_pkg::jgm_tap_state_t state;
  jgm_pkg::jgm_tap_state_t next_state;

  always_comb begin
    case (state)
      jgm_pkg::ST_RESET:    next_state = tms_eff ? jgm_pkg::ST_RESET   : jgm_pkg::ST_IDLE;
      jgm_pkg::ST_IDLE:     next_state = tms_eff ? jgm_pkg::ST_SEL_DR  : jgm_pkg::ST_IDLE;
      jgm_pkg::ST_SEL_DR:   next_state = tms_eff ? jgm_pkg::ST_SEL_IR  : jgm_pkg::ST_CAP_DR;
      jgm_pkg::ST_CAP_DR:   next_state = tms_eff ? jgm_pkg::ST_EXIT1_DR : jgm_pkg::ST_SHIFT_DR;
      jgm_pkg::ST_SHIFT_DR: next_state = tms_eff ? jgm_pkg::ST_EXIT1_DR : jgm_pkg::ST_SHIFT_DR;
      jgm_pkg::ST_EXIT1_DR: next_state = tms_eff ? jgm_pkg::ST_UPD_DR  : jgm_pkg::ST_PAUSE_DR;
      jgm_pkg::ST_PAUSE_DR: next_state = tms_eff ? jgm_pkg::ST_EXIT2_DR : jgm_pkg::ST_PAUSE_DR;
      jgm_pkg::ST_EXIT2_DR: next_state = tms_eff ? jgm_pkg::ST_UPD_DR  : jgm_pkg::ST_SHIFT_DR;
      jgm_pkg::ST_UPD_DR:   next_state = tms_eff ? jgm_pkg::ST_SEL_DR  : jgm_pkg::ST_IDLE;
      jgm_pkg::ST_SEL_IR:   next_state = tms_eff ? jgm_pkg::ST_RESET   : jgm_pkg::ST_CAP_IR;
      jgm_pkg::ST_CAP_IR:   next_state = tms_eff ? jgm_pkg::ST_EXIT1_IR : jgm_pkg::ST_SHIFT_IR;
      jgm_pkg::ST_SHIFT_IR: next_state = tms_eff ? jgm_pkg::ST_EXIT1_IR : jgm_pkg::ST_SHIFT_IR;
      jgm_pkg::ST_EXIT1_IR: next_state = tms_eff ? jgm_pkg::ST_UPD_IR  : jgm_pkg::ST_PAUSE_IR;
      jgm_pkg::ST_PAUSE_IR: next_state = tms_eff ? jgm_pkg::ST_EXIT2_IR : jgm_pkg::ST_PAUSE_IR;
      jgm_pkg::ST_EXIT2_IR: next_state = tms_eff ? jgm_pkg::ST_UPD_IR  : jgm_pkg::ST_SHIFT_IR;
      jgm_pkg::ST_UPD_IR:   next_state = tms_eff ? jgm_pkg::ST_SEL_DR  : jgm_pkg::ST_IDLE;
      default:              next_state = jgm_pkg::ST_RESET;
    endcase
  end

  // RULE_09 mode-select sampling
  // RULE_07 test clock only
  always_ff @(posedge i_tck or posedge i_rst) begin
    if (i_rst) begin
      state <= jgm_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction and data registers
  logic [jgm_pkg::IR_W-1:0] ir_shift;
  logic [jgm_pkg::IR_W-1:0] ir;
  logic [jgm_pkg::ID_W-1:0] id_shift;
  logic                     bypass_bit;

  wire in_rst_st   = (state == jgm_pkg::ST_RESET);
  wire in_shift_ir = (state == jgm_pkg::ST_SHIFT_IR);
  wire in_shift_dr = (state == jgm_pkg::ST_SHIFT_DR);
  wire shifting    = in_shift_ir | in_shift_dr;
  wire sel_id      = (ir == jgm_pkg::IR_IDCODE);
  wire dr_out      = sel_id ? id_shift[0] : bypass_bit;
  wire shift_out   = in_shift_ir ? ir_shift[0] : dr_out;

  // RULE_03 capture on rise
  always_ff @(posedge i_tck or posedge i_rst) begin
    if (i_rst) begin
      ir_shift   <= jgm_pkg::IR_CAPTURE;
      ir         <= jgm_pkg::IR_IDCODE;
      id_shift   <= jgm_pkg::ID_VALUE;
      bypass_bit <= 1'h0;
    end else begin
      if (in_rst_st) begin
        ir <= jgm_pkg::IR_IDCODE;
      end else if (state == jgm_pkg::ST_UPD_IR) begin
        ir <= ir_shift;
      end
      if (state == jgm_pkg::ST_CAP_IR) begin
        ir_shift <= jgm_pkg::IR_CAPTURE;
      end else if (in_shift_ir) begin
        ir_shift <= {tdi_eff, ir_shift[jgm_pkg::IR_W-1:1]};
      end
      if (state == jgm_pkg::ST_CAP_DR) begin
        id_shift   <= jgm_pkg::ID_VALUE;
        bypass_bit <= 1'h0;
      end else if (in_shift_dr) begin
        id_shift   <= {tdi_eff, id_shift[jgm_pkg::ID_W-1:1]};
        bypass_bit <= tdi_eff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test data output, falling test-clock edges
  logic tdo_q;
  logic tdo_oe;

  // RULE_05 falling-edge update
  // RULE_04 drive only shifting
  always_ff @(negedge i_tck or posedge i_rst) begin
    if (i_rst) begin
      tdo_q  <= jgm_pkg::RST_TDO;
      tdo_oe <= 1'h0;
    end else begin
      tdo_q  <= shift_out;
      tdo_oe <= shifting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive selection
  // RULE_06 per-pin direction
  wire [NUM_PINS-1:0] alt_oe  = alt_sel & gpio_dir;
  wire                tdo_alt = alt_sel[jgm_pkg::PIN_TDO];

  // RULE_08 data-output default
  always_comb begin
    o_pad_drv.out = gpio_out & alt_sel;
    o_pad_drv.oe  = alt_oe;
    o_pad_drv.out[jgm_pkg::PIN_TDO] = tdo_alt ? gpio_out[jgm_pkg::PIN_TDO] : tdo_q;
    o_pad_drv.oe[jgm_pkg::PIN_TDO]  = tdo_alt ? gpio_dir[jgm_pkg::PIN_TDO] : tdo_oe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_reset_primary;
    @(posedge i_clk) disable iff (i_rst) $past(i_rst) |-> (alt_sel == '0);
  endproperty
  a_reset_primary: assert property (p_reset_primary) // RULE_01
    else $error("pin left reset in alternate function");

  property p_alt_both;
    @(posedge i_clk) disable iff (i_rst)
      (alt_sel & ~($past(i_per_en) & $past(i_per_sel))) == '0;
  endproperty
  a_alt_both: assert property (p_alt_both) // RULE_02
    else $error("alternate function without both selects");

  property p_tdi_capture;
    @(posedge i_tck) disable iff (i_rst)
      (in_shift_dr && !sel_id) |=> (bypass_bit == $past(tdi_eff));
  endproperty
  a_tdi_capture: assert property (p_tdi_capture) // RULE_03
    else $error("serial input bit not captured");

  property p_tdo_drive;
    @(negedge i_tck) disable iff (i_rst) ##1 (tdo_oe == $past(shifting));
  endproperty
  a_tdo_drive: assert property (p_tdo_drive) // RULE_04
    else $error("data output enable outside shift states");

  property p_tdo_fall;
    @(negedge i_tck) disable iff (i_rst) shifting |=> (tdo_q == $past(shift_out));
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) // RULE_05
    else $error("data output not updated on falling edge");

  property p_gpio_dir;
    @(posedge i_clk) disable iff (i_rst)
      ((o_pad_drv.oe ^ $past(i_gpio_dir)) & alt_sel & $past(alt_sel)) == '0;
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) // RULE_06
    else $error("port direction not applied");

  property p_tdo_default;
    @(posedge i_clk) disable iff (i_rst)
      !alt_sel[jgm_pkg::PIN_TDO] |-> (o_pad_drv.out[jgm_pkg::PIN_TDO] == tdo_q);
  endproperty
  a_tdo_default: assert property (p_tdo_default) // RULE_08
    else $error("data output pin not in test function");

  property p_tms_shift_hold;
    @(posedge i_tck) disable iff (i_rst) (in_shift_dr && !tms_eff) |=> in_shift_dr;
  endproperty
  a_tms_shift_hold: assert property (p_tms_shift_hold) // RULE_09
    else $error("controller left shift with mode select low");

  property p_pullup_reset;
    @(posedge i_tck) disable iff (i_rst) alt_t[jgm_pkg::PIN_TMS] [*5] |=> in_rst_st;
  endproperty
  a_pullup_reset: assert property (p_pullup_reset) // RULE_10
    else $error("mode select not held high in port function");

  c_shift_dr: cover property (@(posedge i_tck) disable iff (i_rst) in_shift_dr ##1 in_shift_dr);
  c_upd_ir:   cover property (@(posedge i_tck) disable iff (i_rst)
                              state == jgm_pkg::ST_UPD_IR);
  c_alt_tdo:  cover property (@(posedge i_clk) disable iff (i_rst)
                              alt_sel[jgm_pkg::PIN_TDO] && gpio_dir[jgm_pkg::PIN_TDO]);

endmodule // jgm_pin_mux

// >>> core/jgm_pkg.sv
// Shared constants and types for the test-port pin multiplexer
package jgm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin positions within the four-pin group
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned PIN_TDI  = 0;  // port_d_pin0
  localparam int unsigned PIN_TDO  = 1;  // port_d_pin1
  localparam int unsigned PIN_TCK  = 2;  // port_d_pin2
  localparam int unsigned PIN_TMS  = 3;  // port_d_pin3

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [3:0] RST_ALT_SEL = 4'h0;  // All pins in test-port function
  localparam logic [3:0] RST_CFG     = 4'h0;
  localparam logic       RST_TDO     = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  localparam int unsigned IR_W        = 4;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [3:0]  IR_IDCODE   = 4'h2;
  localparam logic [3:0]  IR_BYPASS   = 4'hf;
  localparam int unsigned ID_W        = 32;
  // Identification value is arbitrary
  localparam logic [31:0] ID_VALUE    = 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////////////
  // Access-port controller states
  typedef enum logic [3:0] {
    ST_RESET   = 4'h0, ST_IDLE     = 4'h1, ST_SEL_DR   = 4'h2, ST_CAP_DR  = 4'h3,
    ST_SHIFT_DR = 4'h4, ST_EXIT1_DR = 4'h5, ST_PAUSE_DR = 4'h6, ST_EXIT2_DR = 4'h7,
    ST_UPD_DR  = 4'h8, ST_SEL_IR   = 4'h9, ST_CAP_IR   = 4'ha, ST_SHIFT_IR = 4'hb,
    ST_EXIT1_IR = 4'hc, ST_PAUSE_IR = 4'hd, ST_EXIT2_IR = 4'he, ST_UPD_IR  = 4'hf
  } jgm_tap_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive bundle
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } jgm_pad_drv_t;

endpackage : jgm_pkg

// >>> core/jgm_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
module jgm_sync #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Data
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire  [WIDTH-1:0] agree = ~(s2 ^ s3);

  if (WIDTH < 1) begin : g_chk
    $error("jgm_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1  <= RST_VAL;
      s2  <= RST_VAL;
      s3  <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      s1  <= i_d;
      s2  <= s1;
      s3  <= s2;
      o_q <= (agree & s3) | (~agree & o_q);
    end
  end

endmodule // jgm_sync

// >>> testbench/jgm_jtag_host.sv
// External test-port controller model: test clock, mode select, data in
`timescale 1ns/1ps
module jgm_jtag_host (
  // Test link
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One test-clock period; clock stands still between calls
  // lines set after fall, valid at rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'h1;
    q = tdo;
    #62.5 tck = 1'h0;
  endtask

  // Five mode-high rises reach reset, then idle
  task automatic tap_reset();
    logic q;
    // Start off the system clock's edges
    #7;
    repeat (5) step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
  endtask

  // From idle: shift n bits LSB first through IR or DR, back to idle
  task automatic shift(input int n, input logic ir, input logic [31:0] din,
                       output logic [31:0] dout);
    logic q;
    // Start off the system clock's edges
    #7;
    dout = 32'h0;
    step(1'h1, 1'h1, q);
    if (ir) begin
      step(1'h1, 1'h1, q);
    end
    step(1'h0, 1'h1, q);
    step(1'h0, 1'h1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
  endtask
endmodule // jgm_jtag_host

// >>> testbench/jtag_gpio_pin_mux_tb.sv
// Self-checking bench for the test-port pin multiplexer
`timescale 1ns/1ps
`define CHK(g, e) chk(64'(g), 64'(e))
module jtag_gpio_pin_mux_tb;
  logic                  i_clk;
  logic                  i_rst;
  logic [3:0]            i_per_en;
  logic [3:0]            i_per_sel;
  logic [3:0]            i_gpio_dir;
  logic [3:0]            i_gpio_out;
  logic [3:0]            o_gpio_in;
  logic [3:0]            o_alt_active;
  jgm_pkg::jgm_pad_drv_t o_pad_drv;
  wire logic             tck_w;
  wire logic             tms_w;
  wire logic             tdi_w;
  wire logic [3:0]       pad;
  logic                  last1 = 1'h0;
  logic                  tdo_snap;
  logic                  q1;
  logic [31:0]           q32;
  logic [31:0]           din;
  logic [3:0]            alt;
  int                    err_total;
  int                    n_checks;
  int                    oe_rises;
  int unsigned           seed_q;

  // Undriven tdo pad shows the inverse of its last value; others follow the host's tdi, tck and tms lines
  always @(o_pad_drv) if (o_pad_drv.oe[1]) last1 = o_pad_drv.out[1];
  assign pad[0] = o_pad_drv.oe[0] ? o_pad_drv.out[0] : tdi_w;
  assign pad[1] = o_pad_drv.oe[1] ? o_pad_drv.out[1] : ~last1;
  assign pad[2] = o_pad_drv.oe[2] ? o_pad_drv.out[2] : tck_w;
  assign pad[3] = o_pad_drv.oe[3] ? o_pad_drv.out[3] : tms_w;

  jgm_pin_mux i_jgm_pin_mux (.i_clk(i_clk), .i_rst(i_rst), .i_tck(tck_w),
    .i_per_en(i_per_en), .i_per_sel(i_per_sel), .i_gpio_dir(i_gpio_dir),
    .i_gpio_out(i_gpio_out), .o_gpio_in(o_gpio_in), .o_alt_active(o_alt_active),
    .i_pad(pad), .o_pad_drv(o_pad_drv));
  jgm_jtag_host i_jgm_jtag_host (.tck(tck_w), .tms(tms_w), .tdi(tdi_w), .tdo(pad[1]));

  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bypass: one stage delay, captured zero first
  function automatic logic [7:0] byp(input logic [7:0] d);
    return {d[6:0], 1'h0};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Link monitors
  always @(negedge tck_w) #1 tdo_snap = o_pad_drv.out[1];
  always @(posedge tck_w) begin
    if (o_pad_drv.oe[1] === 1'h1 && o_alt_active[1] === 1'h0) begin
      oe_rises++;
      `CHK(o_pad_drv.out[1], tdo_snap);
    end
  end

  initial begin
    #3ms;
    err_total++;
    give_verdict();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    oe_rises = 0;
    seed_q = $urandom(32'h564da8ca);
    {i_per_en, i_per_sel, i_gpio_dir, i_gpio_out} = 16'h0;
    i_rst = 1'h1;
    fork
      repeat (12) @(negedge i_clk);
      repeat (3) i_jgm_jtag_host.step(1'h1, 1'h1, q1);
    join
    i_rst = 1'h0;
    repeat (2) @(negedge i_clk);
    `CHK(o_alt_active, 4'h0);
    `CHK(o_pad_drv.oe, 4'h0);
    i_jgm_jtag_host.tap_reset();
    oe_rises = 0;
    i_jgm_jtag_host.shift(32, 1'h0, $urandom, q32);
    `CHK(q32, jgm_pkg::ID_VALUE);
    `CHK(oe_rises, 32);
    oe_rises = 0;
    i_jgm_jtag_host.shift(4, 1'h1, 32'hf, q32);
    `CHK(q32[3:0], jgm_pkg::IR_CAPTURE);
    `CHK(oe_rises, 4);
    din = $urandom;
    i_jgm_jtag_host.shift(8, 1'h0, din, q32);
    `CHK(q32[7:0], byp(din[7:0]));
    // Let the enable settle after the last test-clock fall
    @(negedge i_clk);
    `CHK(o_pad_drv.oe[1], 1'h0);
    // Port function on data and mode pins freezes the controller in reset
    @(negedge i_clk);
    {i_per_en, i_per_sel} = 8'h99;
    repeat (3) @(negedge i_clk);
    i_jgm_jtag_host.tap_reset();
    oe_rises = 0;
    i_jgm_jtag_host.shift(32, 1'h0, 32'h0, q32);
    `CHK(oe_rises, 0);
    @(negedge i_clk);
    {i_per_en, i_per_sel} = 8'h00;
    repeat (3) @(negedge i_clk);
    repeat (2) i_jgm_jtag_host.tap_reset();
    i_jgm_jtag_host.shift(32, 1'h0, 32'h0, q32);
    `CHK(q32, jgm_pkg::ID_VALUE);
    // Selection: corners first, then random
    for (int i = 0; i < 40; i++) begin
      @(negedge i_clk);
      i_per_en = (i < 3) ? 4'hf : 4'($urandom);
      i_per_sel = (i == 1) ? 4'h0 : (i == 2) ? 4'h5 : 4'($urandom);
      i_gpio_dir = (i == 0) ? 4'hf : 4'($urandom);
      i_gpio_out = 4'($urandom);
      @(negedge i_clk);
      alt = i_per_en & i_per_sel;
      `CHK(o_alt_active, alt);
      `CHK(o_pad_drv.oe & alt, alt & i_gpio_dir);
      `CHK(o_pad_drv.out & alt & i_gpio_dir, i_gpio_out & alt & i_gpio_dir);
      `CHK(o_pad_drv.oe & ~alt & 4'hd, 4'h0);
      repeat (5) @(negedge i_clk);
      `CHK(o_gpio_in, pad);
    end
    // Mid-run reset puts every pin back in test function
    @(negedge i_clk);
    {i_per_en, i_per_sel} = 8'hff;
    @(negedge i_clk);
    i_rst = 1'h1;
    @(negedge i_clk);
    `CHK(o_alt_active, 4'h0);
    `CHK(o_pad_drv.oe, 4'h0);
    {i_per_en, i_per_sel, i_gpio_dir, i_gpio_out} = 16'h0;
    repeat (11) @(negedge i_clk);
    i_rst = 1'h0;
    repeat (2) @(negedge i_clk);
    `CHK(o_alt_active, 4'h0);
    i_jgm_jtag_host.tap_reset();
    i_jgm_jtag_host.shift(32, 1'h0, 32'h0, q32);
    `CHK(q32, jgm_pkg::ID_VALUE);
    give_verdict();
  end
endmodule // jtag_gpio_pin_mux_tb
